// File: pkg/pwr_ctl_pkg.sv
package pwr_ctl_pkg;
	// register offsets
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h1;
	localparam logic [3:0] ADDR_IMASK   = 4'h2;
	localparam logic [3:0] ADDR_MODE_STAT = 4'h3;
	localparam logic [3:0] ADDR_CMD     = 4'h4;
	localparam logic [3:0] ADDR_IRQ     = 4'h5;
	// control register fields
	localparam int CTRL_FORCE_BIT   = 0;
	localparam int CTRL_CLRCTX_BIT  = 1;
	localparam int CTRL_XTALOFF_BIT = 2;
	localparam int CTRL_CKODIS_BIT  = 3;
	localparam int CTRL_BOOT_BIT    = 4;
	localparam int CTRL_GIE_BIT     = 5;
	// command register: bit 0 idle, bits 3:1 divisor code
	localparam int CMD_IDLE_BIT = 0;
	// divisor codes: 0 none, 1..4 -> 16,32,64,128
	localparam logic [2:0] DIV_NONE = 3'h0;
	localparam logic [7:0] DIV16    = 8'h10;
	// reset values
	localparam logic [7:0]  CTRL_RESET   = 8'h20;
	localparam logic [11:0] IMASK_RESET  = 12'h000;
	localparam logic [7:0]  MODE_STAT_RESET = 8'h00;
	localparam logic [15:0] BOOT_ADDR    = 16'h0000;
	// timing in input-clock cycles; this core runs on the input clock
	localparam int WAKE_FAST_CYC = 200;
	localparam int WAKE_CRYSTAL_DRIVE_PIN_CYC = 4096;
	localparam int BOOT_CYC      = 32;
endpackage

// File: logic/cycle_clock_gen.sv
`timescale 1ns/100ps
// makes a processor-rate enable/clock pair from the input clock with a
// slow-idle divisor; output registered
module cycle_clock_gen (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic [7:0] divisor,
	input  wire logic       gateOff,
	// outputs
	output logic            cycleTick,
	output logic            clockOut
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
		logic       ck;
	} gen_t;
	gen_t s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (divisor == 8'h00 || s_reg.cnt + 8'h01 >= divisor) begin
			s_next.cnt = 8'h00;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 8'h01;
		end
		// undivided: toggles every edge; divided: one pulse per period
		s_next.ck = gateOff ? 1'b0 : ((divisor == 8'h00) ? ~s_reg.ck : s_next.tick);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cycleTick = s_reg.tick;
	assign clockOut  = s_reg.ck;

	a_gate_off: assert property (@(posedge clk) disable iff (rst)
		gateOff ##1 gateOff |-> !clockOut) else $error("clock out not gated");
endmodule

// File: logic/dsp_power_idle_reset_control.sv
`timescale 1ns/100ps
module dsp_power_idle_reset_control #(
	parameter int CRYSTAL_DRIVE_PIN_WAIT = pwr_ctl_pkg::WAKE_CRYSTAL_DRIVE_PIN_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// board pins
	input  wire logic        sleepRequestPin,
	output logic             sleepAckPin,
	output logic             cycleClockOutput,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic [15:0]      regRdData,
	// core side
	input  wire logic [11:0] irqRequests,
	input  wire logic        dmaStealReq,
	input  wire logic        busRequest,
	output logic             dmaStealGrant,
	output logic             coreRun,
	output logic             contextClear,
	output logic             nmiPending,
	output logic [15:0]      fetchAddr
);
	typedef enum logic [2:0] {ST_BOOT, ST_RUN, ST_IDLE, ST_SLEEP, ST_WAKE} state_t;
	typedef struct packed {
		state_t      st;
		logic [7:0]  ctrl;
		logic [11:0] imask;
		logic [7:0]  modeStat;
		logic [7:0]  divisor;
		logic [12:0] cnt;
		logic        pinPrev;
		logic        nmi;
		logic        ack;
		logic        run;
		logic        ctxClr;
		logic        grant;
		logic [15:0] rd;
		logic [15:0] fetch;
	} ctl_t;
	ctl_t s_reg, s_next;
	logic        tick;
	logic        ckOut;
	logic        wakeEvent;
	logic [12:0] wakeLen;

	cycle_clock_gen u_clk (
		.clk      (clk),
		.rst      (rst),
		.divisor  ((s_reg.st == ST_IDLE) ? s_reg.divisor : 8'h00),
		.gateOff  (s_reg.ctrl[pwr_ctl_pkg::CTRL_CKODIS_BIT] || s_reg.st == ST_SLEEP),
		.cycleTick(tick),
		.clockOut (ckOut)
	);

	// power-down is left by an interrupt of any kind, mask ignored
	assign wakeEvent = (|irqRequests) || (sleepRequestPin && !s_reg.pinPrev);
	assign wakeLen = s_reg.ctrl[pwr_ctl_pkg::CTRL_XTALOFF_BIT]
		? 13'(CRYSTAL_DRIVE_PIN_WAIT) : 13'(pwr_ctl_pkg::WAKE_FAST_CYC);

	always_comb begin
		s_next = s_reg;
		s_next.pinPrev = sleepRequestPin;
		s_next.grant = dmaStealReq;
		s_next.rd = 16'h0000;
		// edge-sensitive; set beats clear
		if (sleepRequestPin && !s_reg.pinPrev) begin
			s_next.nmi = 1'b1;
		end else if (regWrite && regAddr == pwr_ctl_pkg::ADDR_IRQ && regWrData[0]) begin
			s_next.nmi = 1'b0;
		end
		if (regWrite) begin
			unique case (regAddr)
				pwr_ctl_pkg::ADDR_CTRL:  s_next.ctrl = regWrData[7:0];
				pwr_ctl_pkg::ADDR_IMASK: s_next.imask = regWrData[11:0];
				pwr_ctl_pkg::ADDR_MODE_STAT: s_next.modeStat = regWrData[7:0];
				default: ;
			endcase
		end
		if (regRead) begin
			unique case (regAddr)
				pwr_ctl_pkg::ADDR_CTRL:   s_next.rd = {8'h00, s_reg.ctrl};
				pwr_ctl_pkg::ADDR_STATUS: s_next.rd = {10'h000, s_reg.nmi, s_reg.ack, 1'b0, 3'(s_reg.st)};
				pwr_ctl_pkg::ADDR_IMASK:  s_next.rd = {4'h0, s_reg.imask};
				pwr_ctl_pkg::ADDR_MODE_STAT: s_next.rd = {8'h00, s_reg.modeStat};
				default:                  s_next.rd = 16'h0000;
			endcase
		end
		unique case (s_reg.st)
			ST_BOOT: begin
				s_next.run = 1'b0;
				if (busRequest) begin
					s_next.cnt = 13'h0000;
				end else if (!s_reg.ctrl[pwr_ctl_pkg::CTRL_BOOT_BIT]
					|| s_reg.cnt >= 13'(pwr_ctl_pkg::BOOT_CYC - 1)) begin
					s_next.st = ST_RUN;
					s_next.run = 1'b1;
					s_next.fetch = pwr_ctl_pkg::BOOT_ADDR;
				end else begin
					s_next.cnt = s_reg.cnt + 13'h0001;
				end
			end
			ST_RUN: begin
				s_next.ctxClr = 1'b0;
				if (s_reg.ctrl[pwr_ctl_pkg::CTRL_FORCE_BIT]) begin
					s_next.st = ST_SLEEP;
					s_next.ack = 1'b1;
					s_next.run = 1'b0;
					s_next.ctrl[pwr_ctl_pkg::CTRL_FORCE_BIT] = 1'b0;
				end else if (regWrite && regAddr == pwr_ctl_pkg::ADDR_CMD
					&& regWrData[pwr_ctl_pkg::CMD_IDLE_BIT]) begin
					s_next.st = ST_IDLE;
					s_next.run = 1'b0;
					s_next.divisor = (regWrData[3:1] == pwr_ctl_pkg::DIV_NONE) ? 8'h00
						: 8'(pwr_ctl_pkg::DIV16 << (regWrData[3:1] - 3'h1));
				end
			end
			ST_IDLE: begin
				// the wake waits for the next divided tick: at most n cycles
				if ((|(irqRequests & s_reg.imask)) && tick) begin
					s_next.st = ST_RUN;
					s_next.run = 1'b1;
					s_next.divisor = 8'h00;
				end
			end
			ST_SLEEP: begin
				if (wakeEvent) begin
					s_next.st = ST_WAKE;
					s_next.ack = 1'b0;
					s_next.cnt = 13'h0000;
				end
			end
			ST_WAKE: begin
				if (s_reg.cnt >= wakeLen - 13'h0001) begin
					s_next.st = ST_RUN;
					s_next.run = 1'b1;
					s_next.ctxClr = s_reg.ctrl[pwr_ctl_pkg::CTRL_CLRCTX_BIT];
				end else begin
					s_next.cnt = s_reg.cnt + 13'h0001;
				end
			end
		endcase
	end

	// synchronous reset also aborts power-down; no stabilisation wait
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.st <= ST_BOOT;
			s_reg.ctrl <= pwr_ctl_pkg::CTRL_RESET;
			s_reg.imask <= pwr_ctl_pkg::IMASK_RESET;
			s_reg.modeStat <= pwr_ctl_pkg::MODE_STAT_RESET;
			s_reg.fetch <= pwr_ctl_pkg::BOOT_ADDR;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sleepAckPin      = s_reg.ack;
	assign cycleClockOutput = ckOut;
	assign regRdData        = s_reg.rd;
	assign dmaStealGrant    = s_reg.grant;
	assign coreRun          = s_reg.run;
	assign contextClear     = s_reg.ctxClr;
	assign nmiPending       = s_reg.nmi;
	assign fetchAddr        = s_reg.fetch;

	a_ack_sleep: assert property (@(posedge clk) disable iff (rst)
		sleepAckPin == (s_reg.st == ST_SLEEP)) else $error("ack mismatch");
	a_force_enter: assert property (@(posedge clk) disable iff (rst)
		s_reg.st == ST_RUN && s_reg.ctrl[0] |=> s_reg.st == ST_SLEEP) else $error("no power-down");
	a_nmi_edge: assert property (@(posedge clk) disable iff (rst)
		$rose(sleepRequestPin) |=> nmiPending) else $error("nmi missed");
	a_wake_fast: assert property (@(posedge clk) disable iff (rst)
		s_reg.st == ST_SLEEP && wakeEvent && !s_reg.ctrl[2] |-> ##[1:201] coreRun) else $error("slow wake");
	a_ack_drop: assert property (@(posedge clk) disable iff (rst)
		s_reg.st == ST_SLEEP && wakeEvent |=> !sleepAckPin) else $error("ack held");
	a_reset_exit: assert property (@(posedge clk)
		rst |=> s_reg.st == ST_BOOT && !sleepAckPin && s_reg.imask == 12'h000) else $error("reset");
	a_idle_wake: assert property (@(posedge clk) disable iff (rst)
		s_reg.st == ST_IDLE && (|(irqRequests & s_reg.imask)) |-> ##[1:129] coreRun) else $error("idle wake");
	a_dma_grant: assert property (@(posedge clk) disable iff (rst)
		dmaStealReq |=> dmaStealGrant) else $error("no grant");
	a_boot_fetch: assert property (@(posedge clk) disable iff (rst)
		$rose(coreRun) && $past(s_reg.st) == ST_BOOT |-> fetchAddr == 16'h0000) else $error("boot addr");
endmodule

// File: bench/board_model.sv
`timescale 1ns/100ps
module board_model (
	// clock
	input  wire logic clk,
	// bench command
	input  wire logic pulse,
	// pin towards the device
	output logic      sleepRequestPin
);
	logic [2:0] holdCnt = 3'h0;
	// held several cycles so the device cannot miss the edge
	always_ff @(posedge clk) begin
		if (pulse)
			holdCnt <= 3'h4;
		else if (holdCnt != 3'h0)
			holdCnt <= holdCnt - 3'h1;
	end
	assign sleepRequestPin = (holdCnt != 3'h0);
endmodule

// File: bench/dsp_power_idle_reset_control_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module dsp_power_idle_reset_control_bench;
	localparam int XW = 16;
	logic        clk = 1'b0, rst = 1'b1, pulse = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic        dmaStealReq = 1'b0, busRequest = 1'b0, sleepRequestPin, sleepAckPin, cycleClockOutput;
	logic        dmaStealGrant, coreRun, contextClear, nmiPending;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000, regRdData, fetchAddr;
	logic [11:0] irqRequests = 12'h000;
	int          errors = 0, comparisons = 0;
	// free-running input clock, never stopped
	always #25 clk = ~clk;
	board_model board_u (.clk(clk), .pulse(pulse), .sleepRequestPin(sleepRequestPin));
	dsp_power_idle_reset_control #(.CRYSTAL_DRIVE_PIN_WAIT(XW)) dut_u (.clk(clk), .rst(rst), .sleepRequestPin(sleepRequestPin),
		.sleepAckPin(sleepAckPin), .cycleClockOutput(cycleClockOutput), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irqRequests(irqRequests),
		.dmaStealReq(dmaStealReq), .busRequest(busRequest), .dmaStealGrant(dmaStealGrant), .coreRun(coreRun),
		.contextClear(contextClear), .nmiPending(nmiPending), .fetchAddr(fetchAddr));
	task automatic finish_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic sel(input int s);
		case (s)
			0: return sleepAckPin;
			1: return coreRun;
			2: return dmaStealGrant;
			default: return cycleClockOutput;
		endcase
	endfunction
	task automatic waitSig(input int s, input logic v, input int lim, output int n);
		n = 0;
		while (sel(s) !== v) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				errors++;
				$display("mismatch wait%0d exp %0h got %0h", s, v, sel(s));
				finish_test();
			end
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		d = regRdData;
	endtask
	task automatic t_reset();
		logic [15:0] d;
		int          n;
		waitSig(1, 1'b1, 40, n);
		`CHK("fetch", 16'h0000, fetchAddr)
		rd(pwr_ctl_pkg::ADDR_CTRL, d);
		`CHK("ctrl", 16'h0020, d)
		rd(pwr_ctl_pkg::ADDR_IMASK, d);
		`CHK("imask", 16'h0000, d)
		rd(pwr_ctl_pkg::ADDR_MODE_STAT, d);
		`CHK("modestat", 16'h0000, d)
		rd(4'hF, d);
		`CHK("unmapped", 16'h0000, d)
	endtask
	task automatic t_cycle_clock_output();
		logic b;
		@(posedge clk);
		#1;
		b = cycleClockOutput;
		@(posedge clk);
		#1;
		`CHK("toggle", ~b, cycleClockOutput)
		wr(pwr_ctl_pkg::ADDR_CTRL, 16'h0028);
		repeat (3) @(posedge clk);
		#1;
		`CHK("gated", 1'b0, cycleClockOutput)
		@(posedge clk);
		#1;
		`CHK("gated", 1'b0, cycleClockOutput)
		wr(pwr_ctl_pkg::ADDR_CTRL, 16'h0020);
	endtask
	task automatic t_sleep(input logic [15:0] c, input int minW);
		int n;
		wr(pwr_ctl_pkg::ADDR_CTRL, c);
		waitSig(0, 1'b1, 4, n);
		`CHK("run", 1'b0, coreRun)
		// the gate follows the registered state one edge later
		@(posedge clk);
		#1;
		`CHK("cycle_clock_output", 1'b0, cycleClockOutput)
		@(posedge clk) irqRequests <= 12'h800;
		waitSig(0, 1'b0, 3, n);
		waitSig(1, 1'b1, 200, n);
		`CHK("xtalwait", 1'b1, n >= minW)
		`CHK("ctxclr", c[1], contextClear)
		@(posedge clk) irqRequests <= 12'h000;
	endtask
	task automatic t_nmi();
		@(posedge clk) pulse <= 1'b1;
		@(posedge clk) pulse <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		`CHK("nmi", 1'b1, nmiPending)
		wr(pwr_ctl_pkg::ADDR_IRQ, 16'h0001);
		@(posedge clk);
		#1;
		`CHK("nmiclr", 1'b0, nmiPending)
	endtask
	task automatic t_idle();
		int n;
		wr(pwr_ctl_pkg::ADDR_IMASK, 16'h0001);
		wr(pwr_ctl_pkg::ADDR_CMD, 16'h0001);
		waitSig(1, 1'b0, 4, n);
		@(posedge clk) dmaStealReq <= 1'b1;
		waitSig(2, 1'b1, 3, n);
		@(posedge clk) irqRequests <= 12'h002;
		repeat (8) @(posedge clk);
		#1;
		`CHK("masked", 1'b0, coreRun)
		@(posedge clk) irqRequests <= 12'h001;
		waitSig(1, 1'b1, 4, n);
		@(posedge clk) irqRequests <= 12'h000;
		dmaStealReq <= 1'b0;
	endtask
	task automatic t_slow();
		int n;
		for (int k = 1; k <= 4; k++) begin
			wr(pwr_ctl_pkg::ADDR_CMD, 16'((k << 1) | 1));
			repeat (4) @(posedge clk);
			#1;
			waitSig(3, 1'b1, 300, n);
			@(posedge clk);
			#1;
			waitSig(3, 1'b1, 300, n);
			`CHK("period", 16 << (k - 1), n + 1)
			@(posedge clk) irqRequests <= 12'h001;
			waitSig(1, 1'b1, (16 << (k - 1)) + 2, n);
			@(posedge clk) irqRequests <= 12'h000;
		end
	endtask
	task automatic t_rst();
		int          n;
		logic [15:0] d;
		wr(pwr_ctl_pkg::ADDR_CTRL, 16'h0021);
		waitSig(0, 1'b1, 4, n);
		rd(pwr_ctl_pkg::ADDR_STATUS, d);
		`CHK("status", 16'h0013, d)
		@(posedge clk) begin
			rst <= 1'b1;
			busRequest <= 1'b1;
		end
		@(posedge clk) rst <= 1'b0;
		#1;
		`CHK("ackrst", 1'b0, sleepAckPin)
		// boot enabled while the bus is still requested
		wr(pwr_ctl_pkg::ADDR_CTRL, 16'h0030);
		repeat (4) @(posedge clk);
		#1;
		`CHK("bootheld", 1'b0, coreRun)
		@(posedge clk) busRequest <= 1'b0;
		waitSig(1, 1'b1, 40, n);
		`CHK("boottime", pwr_ctl_pkg::BOOT_CYC, n)
		`CHK("bootfetch", 16'h0000, fetchAddr)
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_cycle_clock_output();
		t_sleep(16'h0021, 0);
		t_sleep(16'h0027, XW - 4);
		t_nmi();
		t_idle();
		t_slow();
		t_rst();
		finish_test();
	end
endmodule
